// ### hw/pmcp_app.sv
// Application end: software register port driving the command port of the core.
`timescale 1ns/1ps
module pmcp_app
    import pmcp_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [PMCP_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [PMCP_DW-1:0] rdata_o,
    output logic irq_o,
    output logic quad_mode_o,
    pmcp_if.app lnk
);
    // ==========================================================
    // Synchronise the core's status (treated as foreign to be safe).
    logic [6:0] s1_q, s2_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1_q <= 7'h01;
            s2_q <= 7'h01;
        end else begin
            s1_q <= {lnk.queue_ready, lnk.state_ind, lnk.cycle_aborted,
                     lnk.addr_slot_occupied_n};
            s2_q <= s1_q;
        end
    end
    logic occ_n, abt, rdy;
    logic [3:0] st;
    assign occ_n = s2_q[0];
    assign abt = s2_q[1];
    assign st = s2_q[5:2];
    assign rdy = s2_q[6];

    // ==========================================================
    // Registers and sequencer: command, optional burst, address with last mark in dual-port mode.
    typedef enum logic [1:0] {PMCP_A_IDLE = 2'h0, PMCP_A_CMD = 2'h1, PMCP_A_BURST = 2'h3,
                              PMCP_A_ADDR = 2'h2} pmcp_aseq_t;
    pmcp_aseq_t sq_q, sq_d;
    logic [PMCP_DW-1:0] cmd_q, cmd_d, adr_q, adr_d, word_q, word_d;
    logic [PMCP_BURST_W-1:0] bl_q, bl_d;
    logic [3:0] ctrl_q, ctrl_d;
    logic [PMCP_EV_W-1:0] ist_q, ist_d, ien_q, ien_d, ev;
    logic stb_q, stb_d, last_q, last_d, abt_q, occ_q, rdy_q2;
    logic [1:0] hcnt_q, hcnt_d;
    logic hold_q, hold_d;
    logic [PMCP_DW-1:0] rd_d, rd_q;

    assign ev = {rdy & ~rdy_q2, occ_n & ~occ_q, abt & ~abt_q};

    always_comb begin
        sq_d = sq_q;
        cmd_d = cmd_q;
        adr_d = adr_q;
        bl_d = bl_q;
        ctrl_d = ctrl_q;
        ien_d = ien_q;
        word_d = word_q;
        stb_d = 1'b0;
        last_d = 1'b0;
        ctrl_d[PMCP_CTRL_GO] = 1'b0;
        ist_d = ist_q;
        if (wr_i && addr_i == PMCP_REG_IRQ_CLR) ist_d = ist_q & ~wdata_i[PMCP_EV_W-1:0];
        ist_d = ist_d | ev; // set wins over clear
        if (wr_i) begin
            unique case (addr_i)
                PMCP_REG_CMD: cmd_d = wdata_i;
                PMCP_REG_ADDR: adr_d = wdata_i;
                PMCP_REG_BURST: bl_d = wdata_i[PMCP_BURST_W-1:0];
                PMCP_REG_CTRL: ctrl_d = wdata_i[3:0];
                PMCP_REG_IRQ_EN: ien_d = wdata_i[PMCP_EV_W-1:0];
                default: ;
            endcase
        end
        unique case (sq_q)
            PMCP_A_IDLE: if (ctrl_q[PMCP_CTRL_GO] && occ_n && rdy) begin // R11
                sq_d = PMCP_A_CMD;
            end
            PMCP_A_CMD: if (st == 4'(PMCP_ST_IDLE)) begin // R10
                stb_d = 1'b1;
                word_d = cmd_q;
                sq_d = cmd_q[PMCP_CMD_RD_BIT] ? PMCP_A_BURST : PMCP_A_ADDR;
            end
            PMCP_A_BURST: if (st == 4'(PMCP_ST_BURST)) begin // R10
                stb_d = 1'b1;
                word_d = {{(PMCP_DW-PMCP_BURST_W){1'b0}}, bl_q};
                sq_d = PMCP_A_ADDR;
            end
            PMCP_A_ADDR: if (st == 4'(PMCP_ST_ADDR)) begin // R10
                stb_d = 1'b1;
                // Quad-port mode takes the address in one word and needs no last mark.
                last_d = ~ctrl_q[PMCP_CTRL_QUAD]; // R15
                word_d = adr_q;
                sq_d = PMCP_A_IDLE;
            end
        endcase
        if (ctrl_q[PMCP_CTRL_FLUSH]) sq_d = PMCP_A_IDLE; // R7
        // Hold stays asserted at least two cycles once raised.
        hold_d = hold_q;
        hcnt_d = hcnt_q;
        if (ctrl_q[PMCP_CTRL_HOLD]) begin
            hold_d = 1'b1;
            if (!hold_q) hcnt_d = 2'(PMCP_HOLD_MIN);
        end else if (hcnt_q == 2'h0 || hcnt_q == 2'h1) begin // R2
            hold_d = 1'b0;
        end
        if (hcnt_q != 2'h0) hcnt_d = hcnt_q - 2'h1;
        if (ctrl_q[PMCP_CTRL_HOLD] && !hold_q) hcnt_d = 2'(PMCP_HOLD_MIN);
        rd_d = '0;
        if (rd_i) begin
            unique case (addr_i)
                PMCP_REG_CMD: rd_d = cmd_q;
                PMCP_REG_ADDR: rd_d = adr_q;
                PMCP_REG_BURST: rd_d = {{(PMCP_DW-PMCP_BURST_W){1'b0}}, bl_q};
                PMCP_REG_CTRL: rd_d = {28'h0, ctrl_q};
                PMCP_REG_STATUS: rd_d = {23'h0, sq_q, st, rdy, abt, occ_n};
                PMCP_REG_IRQ_STAT: rd_d = {29'h0, ist_q};
                PMCP_REG_IRQ_EN: rd_d = {29'h0, ien_q};
                default: rd_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sq_q <= PMCP_A_IDLE;
            cmd_q <= PMCP_RST_WORD;
            adr_q <= PMCP_RST_WORD;
            word_q <= PMCP_RST_WORD;
            bl_q <= '0;
            ctrl_q <= 4'h0;
            ist_q <= '0;
            ien_q <= '0;
            stb_q <= 1'b0;
            last_q <= 1'b0;
            abt_q <= 1'b0;
            occ_q <= 1'b1;
            rdy_q2 <= 1'b0;
            hcnt_q <= 2'h0;
            hold_q <= 1'b0;
            rd_q <= '0;
        end else begin
            sq_q <= sq_d;
            cmd_q <= cmd_d;
            adr_q <= adr_d;
            word_q <= word_d;
            bl_q <= bl_d;
            ctrl_q <= ctrl_d;
            ist_q <= ist_d;
            ien_q <= ien_d;
            stb_q <= stb_d;
            last_q <= last_d;
            abt_q <= abt;
            occ_q <= occ_n;
            rdy_q2 <= rdy;
            hcnt_q <= hcnt_d;
            hold_q <= hold_d;
            rd_q <= rd_d;
        end
    end

    assign lnk.cmd_strobe_n = ~stb_q; // R9
    assign lnk.last_cycle_n = ~last_q; // R15
    assign lnk.cmd_word = word_q;
    assign lnk.master_queue_flush_n = ~ctrl_q[PMCP_CTRL_FLUSH]; // R5
    assign lnk.hold_req_n = ~hold_q; // R1
    assign quad_mode_o = ctrl_q[PMCP_CTRL_QUAD];
    assign rdata_o = rd_q;
    assign irq_o = |(ist_q & ien_q);
endmodule

// ### hw/pmcp_pkg.sv
// Package for the master command port: link constants, state codes and the register map.
// Function
// (R1) Hold request keeps bus request until release/disconnect.
// (R2) Application holds hold request two bus cycles.
// (R3) Core flags aborted master cycle.
// (R4) Core shows four-bit queue interface state.
// (R5) Flush empties queues, returns state to idle.
// (R6) Flush leaves bus-side state machine running.
// (R7) Application should not end transactions by flush.
// (R8) Ready high when operable, low in reset/flush.
// (R9) Strobe captures command, burst length or address.
// (R10) Word meaning follows state and port mode.
// (R11) Address slot flag set; no new transaction then.
// (R12) Write frees slot after all data sent.
// (R13) Read frees slot once all data arrived.
// (R14) Queue clock chosen from two, fixed at configuration.
// (R15) Last-cycle strobe needs command/address strobe too.
// (R16) Flush synchronised before release.
// (R17) State code after flush means idle, awaiting command.
package pmcp_pkg;

    // ==========================================================
    // Link
    localparam int PMCP_DW = 32;
    localparam int PMCP_BURST_W = 8;
    localparam int PMCP_HOLD_MIN = 2;

    // ==========================================================
    // State indicator codes, Gray along the read setup path.
    typedef enum logic [3:0] {
        PMCP_ST_IDLE = 4'h0,
        PMCP_ST_BURST = 4'h1,
        PMCP_ST_ADDR = 4'h3,
        PMCP_ST_BUSY = 4'h2
    } pmcp_state_t;

    // ==========================================================
    // Controller register map (word offsets on the software port).
    localparam logic [3:0] PMCP_REG_CMD = 4'h0;
    localparam logic [3:0] PMCP_REG_ADDR = 4'h1;
    localparam logic [3:0] PMCP_REG_BURST = 4'h2;
    localparam logic [3:0] PMCP_REG_CTRL = 4'h3;
    localparam logic [3:0] PMCP_REG_STATUS = 4'h4;
    localparam logic [3:0] PMCP_REG_IRQ_STAT = 4'h5;
    localparam logic [3:0] PMCP_REG_IRQ_CLR = 4'h6;
    localparam logic [3:0] PMCP_REG_IRQ_EN = 4'h7;

    localparam int PMCP_CTRL_GO = 0;
    localparam int PMCP_CTRL_FLUSH = 1;
    localparam int PMCP_CTRL_HOLD = 2;
    localparam int PMCP_CTRL_QUAD = 3;

    localparam int PMCP_EV_ABORT = 0;
    localparam int PMCP_EV_DONE = 1;
    localparam int PMCP_EV_READY = 2;
    localparam int PMCP_EV_W = 3;

    localparam logic [PMCP_DW-1:0] PMCP_RST_WORD = 32'h0000_0000;
    // Command bit 0 set marks a read transaction.
    localparam int PMCP_CMD_RD_BIT = 0;

endpackage

// ### hw/pmcp_if.sv
// Interface joining the application-side controller and the core command port.
`timescale 1ns/1ps
interface pmcp_if
    import pmcp_pkg::*;
();
    logic master_queue_flush_n;
    logic cmd_strobe_n;
    logic last_cycle_n;
    logic [PMCP_DW-1:0] cmd_word;
    logic hold_req_n;
    logic addr_slot_occupied_n;
    logic cycle_aborted;
    logic [3:0] state_ind;
    logic queue_ready;

    modport core (
        input master_queue_flush_n, cmd_strobe_n, last_cycle_n, cmd_word, hold_req_n,
        output addr_slot_occupied_n, cycle_aborted, state_ind, queue_ready
    );
    modport app (
        output master_queue_flush_n, cmd_strobe_n, last_cycle_n, cmd_word, hold_req_n,
        input addr_slot_occupied_n, cycle_aborted, state_ind, queue_ready
    );
endinterface

// ### hw/pmcp_core.sv
// Core end of the master command port: command capture, slot flag and bus request.
`timescale 1ns/1ps
module pmcp_core
    import pmcp_pkg::*;
(
    input wire logic clk_i, // R14
    input wire logic sys_rst_i,
    input wire logic quad_mode_i,
    input wire logic bus_reset_i,
    input wire logic bus_gnt_i,
    input wire logic target_disc_i,
    input wire logic target_abort_i,
    input wire logic data_done_i,
    output logic bus_req_o,
    output logic [PMCP_DW-1:0] cmd_o,
    output logic [PMCP_DW-1:0] addr_o,
    output logic [PMCP_BURST_W-1:0] burst_o,
    output logic is_read_o,
    pmcp_if.core lnk
);
    // ==========================================================
    // Flush and hold request synchronisers.
    logic fl_s1_q, fl_s2_q, hold_s1_q, hold_s2_q;
    logic flush_act;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fl_s1_q <= 1'b1;
            fl_s2_q <= 1'b1;
            hold_s1_q <= 1'b1;
            hold_s2_q <= 1'b1;
        end else begin
            fl_s1_q <= lnk.master_queue_flush_n; // R16
            fl_s2_q <= fl_s1_q;
            hold_s1_q <= lnk.hold_req_n;
            hold_s2_q <= hold_s1_q;
        end
    end
    // The flush may be raised from another clock, so only the synchronised copy is read.
    // A pulse shorter than one clock period can be missed; hold it two cycles at least.
    assign flush_act = ~fl_s2_q; // R5

    // ==========================================================
    // Queue-side state; flush clears the state code and slot flag.
    pmcp_state_t st_q, st_d;
    logic [PMCP_DW-1:0] cmd_q, cmd_d, addr_q, addr_d;
    logic [PMCP_BURST_W-1:0] burst_q, burst_d;
    logic full_q, full_d, abort_q, abort_d, rdy_q, rdy_d;
    logic strobe;
    assign strobe = ~lnk.cmd_strobe_n;

    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        addr_d = addr_q;
        burst_d = burst_q;
        full_d = full_q;
        abort_d = target_abort_i & full_q; // R3
        rdy_d = ~bus_reset_i & ~flush_act; // R8
        unique case (st_q)
            PMCP_ST_IDLE: if (strobe && !full_q) begin // R9 R11
                cmd_d = lnk.cmd_word;
                if (lnk.cmd_word[PMCP_CMD_RD_BIT]) st_d = PMCP_ST_BURST; // R10
                else st_d = PMCP_ST_ADDR;
            end
            PMCP_ST_BURST: if (strobe) begin
                burst_d = lnk.cmd_word[PMCP_BURST_W-1:0]; // R9
                st_d = PMCP_ST_ADDR;
            end
            PMCP_ST_ADDR: if (strobe) begin
                // Quad-port mode carries the address in one word; dual-port in one too,
                // but only the last-cycle marked word closes setup.
                addr_d = lnk.cmd_word; // R9 R10
                if (quad_mode_i || !lnk.last_cycle_n) begin // R15
                    st_d = PMCP_ST_BUSY;
                    full_d = 1'b1; // R11
                end
            end
            PMCP_ST_BUSY: if (data_done_i || target_abort_i) begin // R12 R13
                full_d = 1'b0;
                st_d = PMCP_ST_IDLE;
            end
        endcase
        if (flush_act) begin // R5 R17
            st_d = PMCP_ST_IDLE;
            full_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q <= PMCP_ST_IDLE; // R17
            cmd_q <= PMCP_RST_WORD;
            addr_q <= PMCP_RST_WORD;
            burst_q <= '0;
            full_q <= 1'b0;
            abort_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cmd_q <= cmd_d;
            addr_q <= addr_d;
            burst_q <= burst_d;
            full_q <= full_d;
            abort_q <= abort_d;
            rdy_q <= rdy_d;
        end
    end

    // ==========================================================
    // Bus request; flush does not touch it so a running transaction goes on.
    logic req_q, req_d;
    always_comb begin
        req_d = req_q; // R6
        if (!req_q && (full_q || !hold_s2_q)) req_d = 1'b1;
        else if (req_q && target_disc_i) req_d = 1'b0; // R1
        else if (req_q && bus_gnt_i && hold_s2_q && !full_q) req_d = 1'b0; // R1
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) req_q <= 1'b0;
        else req_q <= req_d;
    end

    assign bus_req_o = req_q;
    assign cmd_o = cmd_q;
    assign addr_o = addr_q;
    assign burst_o = burst_q;
    assign is_read_o = cmd_q[PMCP_CMD_RD_BIT];
    assign lnk.addr_slot_occupied_n = ~full_q; // R11
    assign lnk.cycle_aborted = abort_q; // R3
    assign lnk.state_ind = st_q; // R4
    assign lnk.queue_ready = rdy_q; // R8
endmodule

// ### verif/pmcp_asserts.sv
// Concurrent checks on the link between the application end and the core end.
`timescale 1ns/1ps
module pmcp_asserts
    import pmcp_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic master_queue_flush_n,
    input wire logic cmd_strobe_n,
    input wire logic last_cycle_n,
    input wire logic [PMCP_DW-1:0] cmd_word,
    input wire logic hold_req_n,
    input wire logic addr_slot_occupied_n,
    input wire logic cycle_aborted,
    input wire logic [3:0] state_ind,
    input wire logic queue_ready
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // ==========================================================
    // Helper: flush must have been off long enough to clear the core's synchroniser.
    logic [1:0] calm_q;
    logic [1:0] calm_d;
    logic calm;
    always_comb begin
        calm_d = calm_q;
        if (!master_queue_flush_n) begin
            calm_d = 2'h0;
        end else if (calm_q != 2'h3) begin
            calm_d = calm_q + 2'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            calm_q <= 2'h0;
        end else begin
            calm_q <= calm_d;
        end
    end
    assign calm = (calm_q == 2'h3) && master_queue_flush_n;

    // ==========================================================
    // Setup steps
    sequence s_cmd_take;
        calm && !cmd_strobe_n && state_ind == PMCP_ST_IDLE;
    endsequence
    sequence s_final_addr;
        calm && !cmd_strobe_n && !last_cycle_n && state_ind == PMCP_ST_ADDR;
    endsequence
    sequence s_busy_full;
        state_ind == PMCP_ST_BUSY && !addr_slot_occupied_n;
    endsequence

    a_write_cmd_path: assert property (
        s_cmd_take ##0 !cmd_word[PMCP_CMD_RD_BIT] |=> state_ind == PMCP_ST_ADDR)
        else $error("write command did not lead to address step");
    a_read_cmd_path: assert property (
        s_cmd_take ##0 cmd_word[PMCP_CMD_RD_BIT] |=> state_ind == PMCP_ST_BURST)
        else $error("read command did not lead to burst step");
    a_burst_step: assert property (
        calm && !cmd_strobe_n && state_ind == PMCP_ST_BURST |=> state_ind == PMCP_ST_ADDR)
        else $error("burst word did not lead to address step");
    a_addr_fills_slot: assert property (s_final_addr |=> s_busy_full)
        else $error("final address did not fill the slot");
    a_full_no_cmd: assert property (!addr_slot_occupied_n |-> cmd_strobe_n)
        else $error("strobe while address slot occupied");
    a_flush_to_idle: assert property (
        $fell(master_queue_flush_n)
        |-> ##[1:4] (state_ind == PMCP_ST_IDLE && addr_slot_occupied_n))
        else $error("flush did not return to idle with slot free");
    a_ready_off_flush: assert property (!master_queue_flush_n [*4] |-> !queue_ready)
        else $error("ready high during flush");
    a_abort_pulse: assert property (cycle_aborted |=> !cycle_aborted)
        else $error("abort flag longer than one cycle");
    a_state_code: assert property (state_ind[3:2] == 2'h0)
        else $error("state indicator outside its codes");
    a_last_with_strobe: assert property (!last_cycle_n |-> !cmd_strobe_n)
        else $error("last-cycle mark without strobe");
    a_hold_min_two: assert property ($fell(hold_req_n) |=> !hold_req_n)
        else $error("hold request shorter than two cycles");
endmodule

// ### verif/test_pci_master_command_port.sv
// Self-checking bench for the application and core ends of the command port.
`timescale 1ns/1ps
module test_pci_master_command_port
    import pmcp_pkg::*;
;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic bus_reset = 1'b0;
    logic bus_gnt = 1'b0;
    logic target_disc = 1'b0;
    logic target_abort = 1'b0;
    logic data_done = 1'b0;
    logic [31:0] rdata;
    logic [31:0] cmd_out;
    logic [31:0] addr_out;
    logic [7:0] burst;
    logic irq;
    logic quad;
    logic bus_req;
    logic is_read;
    logic [31:0] got;
    logic rb;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;

    always #2 clk_i = ~clk_i;

    pmcp_if lnk ();
    pmcp_app i_pmcp_app (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .quad_mode_o(quad), .lnk(lnk));
    pmcp_core i_pmcp_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .quad_mode_i(quad),
        .bus_reset_i(bus_reset), .bus_gnt_i(bus_gnt), .target_disc_i(target_disc),
        .target_abort_i(target_abort), .data_done_i(data_done), .bus_req_o(bus_req),
        .cmd_o(cmd_out), .addr_o(addr_out), .burst_o(burst), .is_read_o(is_read), .lnk(lnk));
    pmcp_asserts i_pmcp_asserts (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .master_queue_flush_n(lnk.master_queue_flush_n), .cmd_strobe_n(lnk.cmd_strobe_n),
        .last_cycle_n(lnk.last_cycle_n), .cmd_word(lnk.cmd_word), .hold_req_n(lnk.hold_req_n),
        .addr_slot_occupied_n(lnk.addr_slot_occupied_n), .cycle_aborted(lnk.cycle_aborted),
        .state_ind(lnk.state_ind), .queue_ready(lnk.queue_ready));

    // ==========================================================
    // Access and compare tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Status polling is bounded; the sequencer lags the core by a synchroniser.
    task automatic wait_st(input logic [31:0] m, input logic [31:0] e);
        for (int i = 0; i < 40; i++) begin
            reg_rd(PMCP_REG_STATUS, got);
            if ((got & m) === e) break;
        end
        chk(got & m, e);
    endtask
    task automatic wait_req(input logic e);
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_i);
            #1;
            if (bus_req === e) break;
        end
        chk({31'h0, bus_req}, {31'h0, e});
    endtask
    task automatic pulse(input int k);
        @(posedge clk_i);
        case (k)
            0: data_done <= 1'b1;
            1: target_abort <= 1'b1;
            2: target_disc <= 1'b1;
            default: bus_gnt <= 1'b1;
        endcase
        @(posedge clk_i);
        data_done <= 1'b0;
        target_abort <= 1'b0;
        target_disc <= 1'b0;
        bus_gnt <= 1'b0;
    endtask
    task automatic run_xfer(input logic [31:0] c, input logic [31:0] a, input logic [31:0] ctl);
        reg_wr(PMCP_REG_CMD, c);
        reg_wr(PMCP_REG_BURST, 32'h10);
        reg_wr(PMCP_REG_ADDR, a);
        reg_wr(PMCP_REG_CTRL, ctl);
        wait_st(32'h7f, 32'h14);
        chk(addr_out, a);
        chk(cmd_out, c);
        chk({31'h0, is_read}, {31'h0, c[0]});
        if (c[0]) chk({24'h0, burst}, 32'h10);
    endtask
    task automatic irq_is(input logic e);
        @(posedge clk_i);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        wait_st(32'h7f, 32'h05);
        reg_wr(PMCP_REG_IRQ_CLR, 32'h7);
        $display("test reset done");
        run_xfer(32'h0, 32'h1000_0040, 32'h1);
        pulse(0);
        wait_st(32'h7f, 32'h05);
        reg_rd(PMCP_REG_IRQ_STAT, got);
        chk(got & 32'h2, 32'h2);
        reg_wr(PMCP_REG_IRQ_EN, 32'h2);
        irq_is(1'b1);
        reg_wr(PMCP_REG_IRQ_CLR, 32'h7);
        irq_is(1'b0);
        reg_rd(PMCP_REG_IRQ_STAT, got);
        chk(got, 32'h0);
        $display("test write done");
        run_xfer(32'h1, 32'h2000_0080, 32'h9);
        pulse(0);
        wait_st(32'h7f, 32'h05);
        $display("test quad read done");
        reg_wr(PMCP_REG_IRQ_EN, 32'h1);
        run_xfer(32'h0, 32'h3000_0000, 32'h1);
        pulse(1);
        wait_st(32'h79, 32'h01);
        irq_is(1'b1);
        reg_wr(PMCP_REG_IRQ_CLR, 32'h7);
        reg_wr(PMCP_REG_IRQ_EN, 32'h0);
        $display("test abort done");
        run_xfer(32'h0, 32'h4000_0010, 32'h1);
        rb = bus_req;
        reg_wr(PMCP_REG_CTRL, 32'h2);
        wait_st(32'h7f, 32'h01);
        chk({31'h0, bus_req}, {31'h0, rb});
        reg_wr(PMCP_REG_CTRL, 32'h0);
        wait_st(32'h7f, 32'h05);
        pulse(3);
        wait_req(1'b0);
        $display("test flush done");
        reg_wr(PMCP_REG_CTRL, 32'h4);
        wait_req(1'b1);
        pulse(3);
        #1;
        chk({31'h0, bus_req}, 32'h1);
        pulse(2);
        #1;
        // A disconnect drops the request for one cycle; the held request then returns.
        chk({31'h0, bus_req}, 32'h0);
        wait_req(1'b1);
        reg_wr(PMCP_REG_CTRL, 32'h0);
        repeat (4) @(posedge clk_i);
        pulse(3);
        wait_req(1'b0);
        $display("test hold done");
        @(posedge clk_i);
        bus_reset <= 1'b1;
        wait_st(32'h4, 32'h0);
        @(posedge clk_i);
        bus_reset <= 1'b0;
        wait_st(32'h4, 32'h4);
        $display("test bus reset done");
        finish_test();
    end
endmodule
